//--- lsh_lin_slave.sv
// Notes on behaviour
// [R1] Long bus silence sets bus idle error.
// [R2] Checksum mismatch sets checksum error.
// [R3] Without correction, sync byte not 55h sets sync error.
// [R4] Three unanswered wake-up pulses set timeout.
// [R5] Response not finished in time sets error.
// [R6] UART framing fault sets serial interface error.
// [R7] Good response sets frame complete.
// [R8] New identifier clears frame complete.
// [R9] Sleep command frame sets sleep flag.
// [R10] Control bit 7 enables baud correction.
// [R11] Break found by timing dominant period.
// [R12] Without correction, sync byte checked as 55h.
// [R13] With correction, sync edges retune baud divisor.
// [R14] Eight byte transmit buffer held.
// [R15] Last identifier byte kept in register.
// [R16] Response data kept in eight byte buffer.
// [R17] Identifier received at current rate after sync.
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module lsh_lin_slave #(
   parameter int unsigned IDLE_CYC   = lsh_pkg::BUS_IDLE_MS * lsh_pkg::CYC_PER_MS,
   parameter int unsigned RESP_CYC   = lsh_pkg::RESP_TO_MS * lsh_pkg::CYC_PER_MS,
   parameter int unsigned WPULSE_CYC = lsh_pkg::WAKE_PULSE_US * lsh_pkg::CYC_PER_US,
   parameter int unsigned WWAIT_CYC  = lsh_pkg::WAKE_WAIT_MS * lsh_pkg::CYC_PER_MS
) (
   // Clock and reset.
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_i,
   // Avalon-MM register slave.
   input  wire lsh_pkg::lsh_avs_req_t avs_req_i,
   output var  lsh_pkg::lsh_avs_rsp_t avs_rsp_o,
   // Interrupt.
   output logic                       irq_o,
   // Single-wire bus, low is dominant.
   input  wire logic                  lin_rx_i,
   output logic                       lin_o,
   output logic                       lin_oe_o
);
   import lsh_pkg::*;

   lsh_regs_t   s_r;
   lsh_regs_t   s_nxt;
   logic        rx_fall;
   logic        rx_rise;
   logic        samp;
   logic        byte_done;
   logic        frame_err;
   logic        brk_hit;
   logic        meas_done;
   logic [31:0] brk_thr;
   logic [7:0]  st_set;
   logic [7:0]  st_clr;
   logic [8:0]  sum_w;
   logic [4:0]  widx;

   // Response length from the two length bits of the identifier.
   function automatic logic [3:0] data_len(input logic [7:0] id);
      logic [3:0] n;
      n = LEN_2;
      unique case (id[5:4])
         2'h0, 2'h1: n = LEN_2;
         2'h2:       n = LEN_4;
         2'h3:       n = LEN_8;
      endcase
      return n;
   endfunction

   // Outputs: the bus is only ever pulled dominant, so the driven value is constant.
   assign lin_o    = 1'b0;
   assign lin_oe_o = (s_r.wk == WK_DRIVE);
   assign irq_o    = |(s_r.status & s_r.mask);
   always_comb begin
      avs_rsp_o.readdata    = s_r.rdata;
      avs_rsp_o.waitrequest = (avs_req_i.read | avs_req_i.write) & ~s_r.ack;
   end

   // Next-state logic for the whole block.
   always_comb begin
      s_nxt     = s_r;
      st_set    = 8'h00;
      st_clr    = 8'h00;
      sum_w     = 9'h000;
      widx      = avs_req_i.address[6:2];
      rx_fall   = s_r.rxp & ~lin_rx_i;
      rx_rise   = ~s_r.rxp & lin_rx_i;
      samp      = (s_r.st == ST_BYTE) && (s_r.tmr == 32'h0);
      byte_done = samp && (s_r.bitc == BIT_STOP) && lin_rx_i;
      frame_err = samp && (s_r.bitc == BIT_STOP) && !lin_rx_i;
      meas_done = (s_r.st == ST_MEAS) && rx_fall && (s_r.bitc == MEAS_EDGES);
      brk_thr   = 32'(s_r.div) * 32'(BRK_BITS);
      // Our own wake-up pulse must not be taken for a break.
      brk_hit   = rx_rise && (s_r.lowc >= brk_thr) && (s_r.wk != WK_DRIVE);  // see [R11]
      s_nxt.rxp = lin_rx_i;

      // Capture timer for the dominant period, saturating on a stuck bus.
      if (lin_rx_i) begin
         s_nxt.lowc = 32'h0;
      end else if (s_r.lowc != TMR_MAX) begin
         s_nxt.lowc = s_r.lowc + 32'h1;
      end

      // Bus silence watch: any edge restarts it, the flag sets once per silence.
      if (rx_fall || rx_rise) begin
         s_nxt.idle = 32'h0;
      end else if (s_r.idle != 32'(IDLE_CYC)) begin
         s_nxt.idle = s_r.idle + 32'h1;
         if (s_r.idle == 32'(IDLE_CYC - 1)) begin
            st_set[B_IDLE] = 1'b1;  // see [R1]
         end
      end

      // Register slave: one wait cycle, then the request is taken.
      s_nxt.ack = (avs_req_i.read | avs_req_i.write) & ~s_r.ack;
      if (avs_req_i.read && !s_r.ack) begin
         s_nxt.rdata = 32'h0;
         if (widx == IDX_STATUS) begin
            s_nxt.rdata[7:0] = s_r.status;
         end else if (widx == IDX_CTRL) begin
            s_nxt.rdata[7:0] = s_r.ctrl;
         end else if (widx == IDX_MASK) begin
            s_nxt.rdata[7:0] = s_r.mask;
         end else if (widx == IDX_RXID) begin
            s_nxt.rdata[7:0] = s_r.rx_id;  // see [R15]
         end else if (widx == IDX_DIV) begin
            s_nxt.rdata[15:0] = s_r.div;
         end else if (widx[4:3] == IDX_RXD[4:3]) begin
            s_nxt.rdata[7:0] = s_r.rxd[widx[2:0]];
         end else if (widx[4:3] == IDX_TXD[4:3]) begin
            s_nxt.rdata[7:0] = s_r.txd[widx[2:0]];
         end
      end
      // Only the bits actually returned are cleared, so a late event survives.
      if (avs_req_i.read && s_r.ack && widx == IDX_STATUS) begin
         st_clr = s_r.rdata[7:0];
      end
      if (avs_req_i.write && s_r.ack) begin
         if (avs_req_i.byteenable[0]) begin
            if (widx == IDX_CTRL) begin
               s_nxt.ctrl = avs_req_i.writedata[7:0] & CTRL_WMASK;  // see [R10]
               if (avs_req_i.writedata[C_WAKE] && s_r.wk == WK_OFF) begin
                  s_nxt.wk     = WK_DRIVE;
                  s_nxt.wk_cnt = 32'h0;
                  s_nxt.tries  = 2'h0;
               end
            end else if (widx == IDX_MASK) begin
               s_nxt.mask = avs_req_i.writedata[7:0];
            end else if (widx == IDX_DIV) begin
               s_nxt.div[7:0] = avs_req_i.writedata[7:0];
            end else if (widx[4:3] == IDX_TXD[4:3]) begin
               s_nxt.txd[widx[2:0]] = avs_req_i.writedata[7:0];  // see [R14]
            end
         end
         if (avs_req_i.byteenable[1] && widx == IDX_DIV) begin
            s_nxt.div[15:8] = avs_req_i.writedata[15:8];
         end
      end

      // Header and response receiver.
      unique case (s_r.st)
         ST_IDLE: begin
         end
         ST_MEAS_ARM: begin
            if (rx_fall) begin
               s_nxt.st   = ST_MEAS;
               s_nxt.tmr  = 32'h0;
               s_nxt.bitc = BIT_START;
            end
         end
         ST_MEAS: begin
            // Five falling edges of 55h span eight bit times.
            s_nxt.tmr = s_r.tmr + 32'h1;
            if (s_r.tmr == TMR_MAX) begin
               st_set[B_SYNC] = 1'b1;
               s_nxt.st       = ST_IDLE;
            end else if (meas_done) begin
               s_nxt.div  = 16'((s_r.tmr + 32'h1) >> SYNC_SHIFT);  // see [R13]
               s_nxt.kind = K_ID;
               s_nxt.st   = ST_BYTE_WAIT;  // see [R17]
            end else if (rx_fall) begin
               s_nxt.bitc = s_r.bitc + 4'h1;
            end
         end
         ST_BYTE_WAIT: begin
            if (rx_fall) begin
               s_nxt.st   = ST_BYTE;
               s_nxt.tmr  = 32'(s_r.div >> 1);  // see [R17]
               s_nxt.bitc = BIT_START;
            end
         end
         ST_BYTE: begin
            if (!samp) begin
               s_nxt.tmr = s_r.tmr - 32'h1;
            end else begin
               s_nxt.tmr  = 32'(s_r.div) - 32'h1;
               s_nxt.bitc = s_r.bitc + 4'h1;
               if (s_r.bitc == BIT_START && lin_rx_i) begin
                  s_nxt.st = ST_BYTE_WAIT;  // A glitch, not a start bit.
               end else if (s_r.bitc != BIT_START && s_r.bitc <= BIT_LAST) begin
                  s_nxt.sh = {lin_rx_i, s_r.sh[7:1]};
               end else if (frame_err) begin
                  st_set[B_SER] = 1'b1;  // see [R6]
                  s_nxt.st      = ST_IDLE;
                  s_nxt.resp_on = 1'b0;
               end else if (byte_done) begin
                  unique case (s_r.kind)
                     K_SYNC: begin
                        if (s_r.sh != SYNC_PAT) begin
                           st_set[B_SYNC] = 1'b1;  // see [R3] [R12]
                           s_nxt.st       = ST_IDLE;
                        end else begin
                           s_nxt.kind = K_ID;
                           s_nxt.st   = ST_BYTE_WAIT;
                        end
                     end
                     K_ID: begin
                        s_nxt.rx_id    = s_r.sh;  // see [R15]
                        st_clr[B_DONE] = 1'b1;  // see [R8]
                        s_nxt.nb       = data_len(s_r.sh);
                        s_nxt.idx      = 4'h0;
                        s_nxt.sum      = 8'h00;
                        s_nxt.kind     = K_DATA;
                        s_nxt.resp_on  = 1'b1;
                        s_nxt.resp_cnt = 32'h0;
                        s_nxt.st       = ST_BYTE_WAIT;
                     end
                     K_DATA: begin
                        s_nxt.rxd[s_r.idx[2:0]] = s_r.sh;  // see [R16]
                        // Classic sum with end-around carry.
                        sum_w     = {1'b0, s_r.sum} + {1'b0, s_r.sh};
                        s_nxt.sum = sum_w[7:0] + {7'h00, sum_w[8]};
                        s_nxt.idx = s_r.idx + 4'h1;
                        if (s_r.idx == s_r.nb - 4'h1) begin
                           s_nxt.kind = K_CHK;
                        end
                        s_nxt.st = ST_BYTE_WAIT;
                     end
                     K_CHK: begin
                        s_nxt.resp_on = 1'b0;
                        s_nxt.st      = ST_IDLE;
                        if (s_r.sh == ~s_r.sum) begin
                           st_set[B_DONE] = 1'b1;  // see [R7]
                           if (s_r.rx_id[5:0] == SLEEP_ID && s_r.rxd[0] == SLEEP_CMD) begin
                              st_set[B_SLEEP] = 1'b1;  // see [R9]
                           end
                        end else begin
                           st_set[B_CSUM] = 1'b1;  // see [R2]
                        end
                     end
                  endcase
               end
            end
         end
      endcase

      // Response deadline, counted from the identifier.
      if (s_r.resp_on && !byte_done && !frame_err) begin
         if (s_r.resp_cnt == 32'(RESP_CYC - 1)) begin
            st_set[B_NORESP] = 1'b1;  // see [R5]
            s_nxt.resp_on    = 1'b0;
            s_nxt.st         = ST_IDLE;
         end else begin
            s_nxt.resp_cnt = s_r.resp_cnt + 32'h1;
         end
      end

      // Wake-up: pulse, wait for a header, retry until the tries run out.
      unique case (s_r.wk)
         WK_OFF: begin
         end
         WK_DRIVE: begin
            s_nxt.wk_cnt = s_r.wk_cnt + 32'h1;
            if (s_r.wk_cnt == 32'(WPULSE_CYC - 1)) begin
               s_nxt.wk     = WK_WAIT;
               s_nxt.wk_cnt = 32'h0;
            end
         end
         WK_WAIT: begin
            s_nxt.wk_cnt = s_r.wk_cnt + 32'h1;
            if (s_r.wk_cnt == 32'(WWAIT_CYC - 1)) begin
               s_nxt.wk_cnt = 32'h0;
               if (s_r.tries == WAKE_LAST) begin
                  st_set[B_WTO]       = 1'b1;  // see [R4]
                  s_nxt.wk            = WK_OFF;
                  s_nxt.ctrl[C_WAKE]  = 1'b0;
               end else begin
                  s_nxt.tries = s_r.tries + 2'h1;
                  s_nxt.wk    = WK_DRIVE;
               end
            end
         end
      endcase

      // A break restarts the header whatever the receiver was doing.
      if (brk_hit) begin
         s_nxt.kind         = K_SYNC;
         s_nxt.resp_on      = 1'b0;
         s_nxt.wk           = WK_OFF;
         s_nxt.ctrl[C_WAKE] = 1'b0;
         s_nxt.st           = s_r.ctrl[C_BAUD] ? ST_MEAS_ARM : ST_BYTE_WAIT;  // see [R10] [R12]
      end

      // Sticky status: a set in the clearing cycle wins.
      s_nxt.status = (s_r.status & ~st_clr) | st_set;
   end

   // State register.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s_r     <= '0;
         s_r.div <= DIV_RST;
         s_r.rxp <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence seq_stop_ok;
      byte_done;
   endsequence

   sequence seq_break;
      rx_rise && s_r.lowc >= brk_thr && s_r.wk != WK_DRIVE;
   endsequence

   a_bus_idle_flag: assert property (  // see [R1]
      s_r.idle == 32'(IDLE_CYC - 1) && !rx_fall && !rx_rise |=> s_r.status[B_IDLE])
      else $error("Bus idle error not raised after the silence limit.");
   a_csum_bad_flag: assert property (  // see [R2]
      seq_stop_ok and (s_r.kind == K_CHK && s_r.sh != ~s_r.sum) |=> s_r.status[B_CSUM])
      else $error("Checksum mismatch did not set the checksum error.");
   a_sync_bad_flag: assert property (  // see [R3]
      seq_stop_ok and (s_r.kind == K_SYNC && s_r.sh != SYNC_PAT)
      |=> s_r.status[B_SYNC] && s_r.st == ST_IDLE)
      else $error("Bad sync byte did not set the sync error.");
   a_wake_timeout: assert property (  // see [R4]
      s_r.wk == WK_WAIT && s_r.wk_cnt == 32'(WWAIT_CYC - 1) && s_r.tries == WAKE_LAST
      && !brk_hit |=> s_r.status[B_WTO] && s_r.wk == WK_OFF)
      else $error("Third unanswered wake-up did not time out.");
   a_resp_deadline: assert property (  // see [R5]
      s_r.resp_on && s_r.resp_cnt == 32'(RESP_CYC - 1) && !byte_done && !frame_err
      && !brk_hit |=> s_r.status[B_NORESP] && !s_r.resp_on)
      else $error("Response deadline missed without error.");
   a_framing_flag: assert property (  // see [R6]
      frame_err |=> s_r.status[B_SER] && s_r.st == ST_IDLE)
      else $error("Framing fault did not set the serial error.");
   a_frame_good: assert property (  // see [R7]
      seq_stop_ok and (s_r.kind == K_CHK && s_r.sh == ~s_r.sum) |=> s_r.status[B_DONE])
      else $error("Good response did not set frame complete.");
   a_id_clears: assert property (  // see [R8]
      seq_stop_ok and (s_r.kind == K_ID) |=> !s_r.status[B_DONE] && s_r.rx_id == $past(s_r.sh))
      else $error("Identifier did not clear frame complete or was not kept.");
   a_sleep_flag: assert property (  // see [R9]
      seq_stop_ok and (s_r.kind == K_CHK && s_r.sh == ~s_r.sum && s_r.rx_id[5:0] == SLEEP_ID
      && s_r.rxd[0] == SLEEP_CMD) |=> s_r.status[B_SLEEP])
      else $error("Sleep command did not set the sleep flag.");
   a_break_mode: assert property (  // see [R11]
      seq_break |=> s_r.kind == K_SYNC
      && s_r.st == ($past(s_r.ctrl[C_BAUD]) ? ST_MEAS_ARM : ST_BYTE_WAIT))
      else $error("Break did not start the sync field in the selected mode.");
   a_baud_fix: assert property (  // see [R13]
      meas_done && !brk_hit |=> s_r.div == 16'(($past(s_r.tmr) + 32'h1) >> SYNC_SHIFT)
      && s_r.st == ST_BYTE_WAIT && s_r.kind == K_ID)
      else $error("Sync measurement did not retune the divisor.");
   a_id_at_rate: assert property (  // see [R17]
      s_r.st == ST_BYTE_WAIT && rx_fall && !brk_hit
      |=> s_r.st == ST_BYTE && s_r.tmr == 32'($past(s_r.div) >> 1))
      else $error("Byte start not timed from the current divisor.");
   a_rx_store: assert property (  // see [R16]
      seq_stop_ok and (s_r.kind == K_DATA)
      |=> s_r.rxd[$past(s_r.idx[2:0])] == $past(s_r.sh))
      else $error("Received data byte not stored.");
   a_tx_store: assert property (  // see [R14]
      avs_req_i.write && s_r.ack && avs_req_i.byteenable[0] && widx[4:3] == IDX_TXD[4:3]
      |=> s_r.txd[$past(widx[2:0])] == $past(avs_req_i.writedata[7:0]))
      else $error("Transmit buffer write lost.");
endmodule
`default_nettype wire

//--- lsh_pkg.sv
`default_nettype none
package lsh_pkg;
   // Clock rate and the default link rate.
   localparam int unsigned CLK_HZ     = 40_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
   localparam int unsigned BAUD_DEF   = 19200;
   localparam logic [15:0] DIV_RST    = 16'(CLK_HZ / BAUD_DEF);

   // Timing figures in their own units.
   localparam int unsigned BUS_IDLE_MS   = 4000;
   localparam int unsigned RESP_TO_MS    = 50;
   localparam int unsigned WAKE_PULSE_US = 250;
   localparam int unsigned WAKE_WAIT_MS  = 150;
   localparam int unsigned WAKE_TRIES    = 3;
   localparam logic [1:0]  WAKE_LAST     = 2'(WAKE_TRIES - 1);

   // Frame constants.
   localparam int unsigned BRK_BITS   = 11;
   localparam logic [7:0]  SYNC_PAT   = 8'h55;
   localparam logic [5:0]  SLEEP_ID   = 6'h3C;
   localparam logic [7:0]  SLEEP_CMD  = 8'h00;
   localparam int unsigned SYNC_SHIFT = 3;
   localparam logic [3:0]  MEAS_EDGES = 4'h3;
   localparam logic [3:0]  BIT_START  = 4'h0;
   localparam logic [3:0]  BIT_LAST   = 4'h8;
   localparam logic [3:0]  BIT_STOP   = 4'h9;
   localparam logic [3:0]  LEN_2      = 4'h2;
   localparam logic [3:0]  LEN_4      = 4'h4;
   localparam logic [3:0]  LEN_8      = 4'h8;
   localparam logic [31:0] TMR_MAX    = 32'hFFFF_FFFF;

   // Register word indexes; the byte address is four times the index.
   localparam logic [4:0] IDX_STATUS = 5'h00;
   localparam logic [4:0] IDX_CTRL   = 5'h01;
   localparam logic [4:0] IDX_MASK   = 5'h02;
   localparam logic [4:0] IDX_RXID   = 5'h03;
   localparam logic [4:0] IDX_DIV    = 5'h04;
   localparam logic [4:0] IDX_RXD    = 5'h08;
   localparam logic [4:0] IDX_TXD    = 5'h10;

   // Status bit positions.
   localparam int B_IDLE   = 7;
   localparam int B_CSUM   = 6;
   localparam int B_SYNC   = 5;
   localparam int B_WTO    = 4;
   localparam int B_NORESP = 3;
   localparam int B_SER    = 2;
   localparam int B_DONE   = 1;
   localparam int B_SLEEP  = 0;
   // Control bit positions and the writable bits.
   localparam int         C_BAUD     = 7;
   localparam int         C_WAKE     = 5;
   localparam logic [7:0] CTRL_WMASK = 8'hA0;

   typedef enum logic [2:0] {ST_IDLE, ST_MEAS_ARM, ST_MEAS, ST_BYTE_WAIT, ST_BYTE} lsh_state_t;
   typedef enum logic [1:0] {K_SYNC, K_ID, K_DATA, K_CHK} lsh_kind_t;
   typedef enum logic [1:0] {WK_OFF, WK_DRIVE, WK_WAIT} lsh_wk_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [6:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } lsh_avs_req_t;

   typedef struct packed {
      logic        waitrequest;
      logic [31:0] readdata;
   } lsh_avs_rsp_t;

   typedef struct packed {
      lsh_state_t      st;
      lsh_kind_t       kind;
      lsh_wk_t         wk;
      logic [1:0]      tries;
      logic [31:0]     tmr;
      logic [31:0]     lowc;
      logic [31:0]     idle;
      logic [31:0]     resp_cnt;
      logic            resp_on;
      logic [31:0]     wk_cnt;
      logic [3:0]      bitc;
      logic [3:0]      idx;
      logic [3:0]      nb;
      logic [7:0]      sh;
      logic [7:0]      sum;
      logic [15:0]     div;
      logic            rxp;
      logic            ack;
      logic [31:0]     rdata;
      logic [7:0]      status;
      logic [7:0]      mask;
      logic [7:0]      ctrl;
      logic [7:0]      rx_id;
      logic [7:0][7:0] rxd;
      logic [7:0][7:0] txd;
   } lsh_regs_t;
endpackage
`default_nettype wire

//--- lsh_lin_master.sv
`timescale 1ns/100ps
`default_nettype none
// Link master model; the released line returns recessive through the pull-up.
module lsh_lin_master (
   // Clock, the slave's driven level and its output enable.
   input  wire logic clk_i,
   input  wire logic drv_i,
   input  wire logic oe_i,
   // Resolved line level.
   output logic      bus_o
);
   logic        drv_r = 1'b1;
   int unsigned bt    = 16;
   int unsigned gap   = 2;
   // Wired-AND: the slave's level only counts while its output is enabled.
   assign bus_o = drv_r & (drv_i | ~oe_i);
   // Holds a level for n clocks; entered just after a rising edge.
   task automatic hold(input logic v, input int unsigned n);
      drv_r <= v;
      repeat (n) @(posedge clk_i);
   endtask
   // One character, LSB first; a low stop bit provokes a framing fault.
   task automatic byte_out(input logic [7:0] b, input logic stop);
      hold(1'b0, bt);
      for (int i = 0; i < 8; i++) hold(b[i], bt);
      hold(stop, bt);
      hold(1'b1, gap);
   endtask
   // Identifier with its two parity bits on top.
   function automatic logic [7:0] par(input logic [5:0] id);
      return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
   endfunction
   // Break of 13 bit times, delimiter, sync byte and identifier.
   task automatic header(input logic [7:0] sync, input logic [5:0] id);
      hold(1'b0, 13 * bt);
      hold(1'b1, bt);
      byte_out(sync, 1'b1);
      byte_out(par(id), 1'b1);
   endtask
endmodule
`default_nettype wire

//--- lin_slave_header_status_tb.sv
`timescale 1ns/100ps
`default_nettype none
module lin_slave_header_status_tb;
   import lsh_pkg::*;
   // Frame case: identifier, first data byte, checksum good, status expected.
   typedef struct packed {
      logic [5:0] id;
      logic [7:0] d0;
      logic       good;
      logic [7:0] st;
   } lsh_row_t;
   localparam int unsigned RESP_T = 3000;
   logic         sys_clk = 1'b0;
   logic         rst     = 1'b1;
   lsh_avs_req_t req     = '0;
   lsh_avs_rsp_t rsp;
   logic         irq;
   logic         lin_rx;
   logic         lin_oe;
   logic         lin_drv;
   logic         oe_q    = 1'b0;
   int           n_fail  = 0;
   int           n_tests = 0;
   int           n_oe    = 0;
   int           n0;
   int           nb;
   logic [31:0]  rd;
   logic [7:0]   ed [8];
   lsh_row_t     rows [5] = '{'{6'h01, 8'h12, 1'b1, 8'h02}, '{6'h22, 8'h34, 1'b1, 8'h02},
      '{6'h33, 8'h56, 1'b1, 8'h02}, '{6'h3C, 8'h00, 1'b1, 8'h03}, '{6'h10, 8'h78, 1'b0, 8'h40}};

   // Short counts keep the timeouts within a brief run.
   lsh_lin_slave #(.IDLE_CYC(2000), .RESP_CYC(RESP_T), .WPULSE_CYC(20), .WWAIT_CYC(200)) uut (
      .sys_clk_i(sys_clk), .rst_i(rst), .avs_req_i(req), .avs_rsp_o(rsp), .irq_o(irq),
      .lin_rx_i(lin_rx), .lin_o(lin_drv), .lin_oe_o(lin_oe));
   lsh_lin_master mst (.clk_i(sys_clk), .drv_i(lin_drv), .oe_i(lin_oe), .bus_o(lin_rx));

   // A 25 ns clock.
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Counts wake-up pulses that the slave drives onto the line.
   always @(posedge sys_clk) begin
      oe_q <= lin_oe;
      if (lin_oe && !oe_q) n_oe <= n_oe + 1;
   end

   task automatic complete_run;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One access; waitrequest is sampled at each rising edge and the request stands until it is low.
   task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge sys_clk);
      req <= '{read: !wr, write: wr, address: a, byteenable: 4'hF, writedata: wd};
      do begin
         @(posedge sys_clk);
         k++;
      end while (rsp.waitrequest !== 1'b0 && k < 50);
      rd = rsp.readdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
      if (k >= 50) begin
         n_fail++;
         complete_run();
      end
   endtask
   task automatic rchk(input logic [6:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   // Status read with only the bits under test compared.
   task automatic st_chk(input logic [7:0] m, input logic [7:0] exp);
      bus(1'b0, 7'h00, 32'h0);
      check(rd & {24'h0, m}, {24'h0, exp});
   endtask
   // Whole frame; the checksum is the inverted carry-folded sum.
   task automatic frame(input logic [5:0] id, input logic [7:0] d0, input logic good);
      int s;
      s = 0;
      nb = (id[5:4] == 2'b11) ? 8 : (id[5:4] == 2'b10) ? 4 : 2;
      mst.header(SYNC_PAT, id);
      for (int i = 0; i < nb; i++) begin
         ed[i] = 8'(d0 + 8'(i) * 8'h11);
         mst.byte_out(ed[i], 1'b1);
         s = s + ed[i];
         if (s > 255) s = s - 255;
      end
      mst.byte_out(~8'(s) ^ {7'h00, !good}, 1'b1);
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      // Reset values, an unmapped place and the writable control bits.
      rchk(7'h00, 32'h0);
      rchk(7'h10, {16'h0000, DIV_RST});
      bus(1'b1, 7'h60, 32'hFF);
      rchk(7'h60, 32'h0);
      bus(1'b1, 7'h04, 32'hDF);
      rchk(7'h04, 32'h80);
      bus(1'b1, 7'h04, 32'h00);
      bus(1'b1, 7'h5C, 32'hA5);
      rchk(7'h5C, 32'hA5);
      bus(1'b1, 7'h10, 32'h10);
      bus(1'b1, 7'h08, 32'h02);
      foreach (rows[r]) begin
         frame(rows[r].id, rows[r].d0, rows[r].good);
         check({31'h0, irq}, {31'h0, rows[r].st[1]});
         rchk(7'h00, {24'h0, rows[r].st});
         // The read clears status at the edge that ends it, so irq settles only after it.
         @(negedge sys_clk);
         check({31'h0, irq}, 32'h0);
         rchk(7'h0C, {24'h0, mst.par(rows[r].id)});
         rchk(7'h20 + 7'(4 * (nb - 1)), {24'h0, ed[nb - 1]});
      end
      // A new identifier withdraws the earlier completion; masked flag keeps irq low.
      frame(6'h01, 8'h9A, 1'b1);
      frame(6'h02, 8'hBC, 1'b0);
      check({31'h0, irq}, 32'h0);
      rchk(7'h00, 32'h40);
      mst.header(8'h54, 6'h01);
      st_chk(8'h20, 8'h20);
      // Header with no answer, then silence long enough for the idle flag too.
      mst.header(SYNC_PAT, 6'h05);
      repeat (RESP_T + 100) @(posedge sys_clk);
      st_chk(8'h88, 8'h88);
      n0 = n_oe;
      bus(1'b1, 7'h04, 32'h20);
      // The first wake-up pulse must really pull the line dominant.
      repeat (5) @(posedge sys_clk);
      check({31'h0, lin_rx}, 32'h0);
      repeat (995) @(posedge sys_clk);
      check(32'(n_oe - n0), 32'h3);
      st_chk(8'h10, 8'h10);
      mst.header(SYNC_PAT, 6'h01);
      mst.byte_out(8'hAA, 1'b0);
      st_chk(8'h04, 8'h04);
      repeat (RESP_T + 100) @(posedge sys_clk);
      bus(1'b0, 7'h00, 32'h0);
      // Correction on while the master runs half as slow again as the divisor.
      bus(1'b1, 7'h04, 32'h80);
      mst.bt = 24;
      frame(6'h06, 8'h5A, 1'b1);
      rchk(7'h10, 32'h18);
      st_chk(8'h02, 8'h02);
      rchk(7'h0C, {24'h0, mst.par(6'h06)});
      // Reset in mid-run restores the divisor, control, status and irq.
      rst <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      rchk(7'h10, {16'h0000, DIV_RST});
      rchk(7'h04, 32'h0);
      rchk(7'h00, 32'h0);
      check({31'h0, irq}, 32'h0);
      complete_run();
   end
endmodule
`default_nettype wire
